// file: hdl/chop_seq_pkg.sv
// constants for the four-channel chop sequencer
package chop_seq_pkg;
  // chop period of the primary oscillator
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CHOP_PERIOD_NS = 2000;
  localparam int unsigned CHOP_CYCLES = (CHOP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // secondary free-runs slower, so the primary's sync always arrives first
  localparam int unsigned SEC_EXTRA_CYCLES = 8;
  // blanking pulse covers the switch and settling
  localparam int unsigned BLANK_NS = 40;
  localparam int unsigned BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CH_NUM = 4;
  localparam logic [3:0] CH1_ONEHOT = 4'h1;
  localparam logic [3:0] CH2_ONEHOT = 4'h2;
  localparam logic [3:0] CH3_ONEHOT = 4'h4;
  localparam logic [3:0] CH4_ONEHOT = 4'h8;
endpackage : chop_seq_pkg

// file: hdl/chop_osc.sv
// chop oscillator: free-running or sync-reset pulse generator
`timescale 1ns/100ps
`default_nettype none
module chop_osc #(
  parameter int unsigned PERIOD = chop_seq_pkg::CHOP_CYCLES,
  parameter int unsigned CNT_W = chop_seq_pkg::CNT_W
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // synchronised reset
  input wire logic run_i, // oscillator enabled
  input wire logic sync_i, // sync pulse from a faster oscillator
  output logic pulse_o // one-cycle oscillator pulse
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic pulse_q;
  logic pulse_d;

  always_comb begin
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
    end else if (sync_i || cnt_q == CNT_W'(PERIOD - 1)) begin
      cnt_d = '0;
      pulse_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse_o = pulse_q;
endmodule : chop_osc
`default_nettype wire

// file: hdl/four_channel_chop_sequencer.sv
// four-channel chopped-mode sequencer with beam blanking
// Function
// [RULE1] Chop mode disables the oscillator control so the primary chop oscillator free-runs.
// [RULE2] Each primary oscillator pulse toggles the first-pair select flip-flop.
// [RULE3] The first-pair flip-flop enables channel 1 and channel 2 in turn, never both.
// [RULE4] The second-pair logic works the same but its oscillator is synced by the primary.
// [RULE5] The primary runs slightly faster than the secondary's free rate and so sets its rate.
// [RULE6] The two pair-select flip-flops are locked and change state together.
// [RULE7] The locked flip-flop output triggers the pair-select pulser, giving a count of four.
// [RULE8] In chop mode the pair-select pulser only fires when triggered by the locked output.
// [RULE9] The pair-select flip-flop toggles on pair-select pulses, at half the chop rate.
// [RULE10] In one state the first pair is routed to the output and the second pair blocked.
// [RULE11] In the other state the second pair is routed and the first pair stopped.
// [RULE12] Primary and pair-select pulses go to the blanking amplifier with the secondary's.
// [RULE13] The blanking amplifier inverts the pulses into active-low beam blanking.
// [RULE14] The output order repeats channel 1, 2, 3, 4, one channel at a time.
// [RULE15] Each blanking pulse starts by the channel change and ends after the path settles.
`timescale 1ns/100ps
`default_nettype none
module four_channel_chop_sequencer #(
  parameter int unsigned CHOP_PERIOD = chop_seq_pkg::CHOP_CYCLES,
  parameter int unsigned BLANK_LEN = chop_seq_pkg::BLANK_CYCLES
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic chop_mode_i, // pin: four-channel chop selected
  output logic [3:0] ch_enable_o, // one-hot channel gate to output
  output logic first_pair_sel_o, // first-pair select ff (0 = ch1)
  output logic second_pair_sel_o, // second-pair select ff (0 = ch3)
  output logic pair_sel_o, // pair select ff (0 = pair 1/2)
  output logic blank_n_o // beam blanking, active low
);
  localparam int unsigned CNT_W = chop_seq_pkg::CNT_W;
  localparam int unsigned SEC_PERIOD = CHOP_PERIOD + chop_seq_pkg::SEC_EXTRA_CYCLES;

  logic rst_s1_q;
  logic rst_n_q;
  logic mode_s1_q;
  logic mode_s2_q;

  // reset release synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // mode pin synchroniser
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= chop_mode_i;
      mode_s2_q <= mode_s1_q;
    end
  end

  logic chop_osc_control;
  logic primary_pulse;
  logic secondary_pulse;

  // control stage off in chop mode: the primary free-runs
  assign chop_osc_control = ~mode_s2_q; // RULE1

  chop_osc #(
    .PERIOD(CHOP_PERIOD),
    .CNT_W(CNT_W)
  ) primary_chop_osc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(~chop_osc_control), // RULE1
    .sync_i(1'b0),
    .pulse_o(primary_pulse)
  );

  // longer free period so the primary's sync always wins
  chop_osc #(
    .PERIOD(SEC_PERIOD),
    .CNT_W(CNT_W)
  ) secondary_chop_osc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(mode_s2_q),
    .sync_i(primary_pulse), // RULE4 RULE5
    .pulse_o(secondary_pulse)
  );

  logic first_q;
  logic first_d;
  logic second_q;
  logic second_d;
  logic pair_q;
  logic pair_d;
  logic lock_prev_q;
  logic lock_prev_d;
  logic pair_pulse_q;
  logic pair_pulse_d;
  logic toggle_lock_link;
  logic pair_trigger;

  // both pair ffs are driven by one toggle so they can never drift apart
  assign toggle_lock_link = first_q;
  // falling edge of the locked output every second chop step
  assign pair_trigger = lock_prev_q & ~toggle_lock_link; // RULE7

  always_comb begin
    first_d = first_q;
    second_d = second_q;
    pair_d = pair_q;
    lock_prev_d = toggle_lock_link;
    pair_pulse_d = 1'b0;
    if (!mode_s2_q) begin
      first_d = 1'b0;
      second_d = 1'b0;
      pair_d = 1'b0;
      lock_prev_d = 1'b0;
    end else begin
      if (primary_pulse) begin
        first_d = ~first_q; // RULE2 RULE6
        second_d = ~first_q; // RULE4 RULE6
      end
      // triggered pulser: fires only from the locked ff output
      pair_pulse_d = pair_trigger; // RULE8
      if (pair_pulse_q) begin
        pair_d = ~pair_q; // RULE9
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
      pair_q <= 1'b0;
      lock_prev_q <= 1'b0;
      pair_pulse_q <= 1'b0;
    end else begin
      first_q <= first_d;
      second_q <= second_d;
      pair_q <= pair_d;
      lock_prev_q <= lock_prev_d;
      pair_pulse_q <= pair_pulse_d;
    end
  end

  // routing: the pair ff picks a pair, the pair ffs pick a channel in it
  // for two cycles after first_q falls the old pair still routes; blanking hides that glimpse
  logic [3:0] route_d;
  logic [3:0] route_q;
  always_comb begin
    route_d = '0;
    if (mode_s2_q) begin
      if (!pair_q) begin
        route_d = first_q ? chop_seq_pkg::CH2_ONEHOT : chop_seq_pkg::CH1_ONEHOT; // RULE3 RULE10
      end else begin
        route_d = second_q ? chop_seq_pkg::CH4_ONEHOT : chop_seq_pkg::CH3_ONEHOT; // RULE11
      end
    end
  end

  // blanking: stretched OR of all three oscillator pulse trains
  logic [CNT_W-1:0] blank_cnt_q;
  logic [CNT_W-1:0] blank_cnt_d;
  logic blank_n_q;
  logic blank_n_d;
  logic any_pulse;
  assign any_pulse = primary_pulse | pair_pulse_q | secondary_pulse; // RULE12

  always_comb begin
    blank_cnt_d = blank_cnt_q;
    if (any_pulse) begin
      blank_cnt_d = CNT_W'(BLANK_LEN); // RULE15
    end else if (blank_cnt_q != '0) begin
      blank_cnt_d = blank_cnt_q - CNT_W'(1);
    end
    // pulse is asserted the cycle a change is registered, released after settling
    blank_n_d = ~(any_pulse | (blank_cnt_q > CNT_W'(1))); // RULE13 RULE15
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      route_q <= '0;
      blank_cnt_q <= '0;
      blank_n_q <= 1'b1;
    end else begin
      route_q <= route_d; // RULE14
      blank_cnt_q <= blank_cnt_d;
      blank_n_q <= blank_n_d;
    end
  end

  // helper for the checks: length of the running blanking pulse, wrapping to zero after all ones
  logic [CNT_W-1:0] low_run_q;
  logic [CNT_W-1:0] low_run_d;
  always_comb begin
    low_run_d = '0;
    if (!blank_n_q && low_run_q != '1) begin
      low_run_d = low_run_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= low_run_d;
    end
  end

  // per channel: how long the gate has stood, so no slot can outlast one chop period plus one cycle
  for (genvar ch = 0; ch < chop_seq_pkg::CH_NUM; ch++) begin : g_slot
    logic [CNT_W-1:0] slot_q;
    logic [CNT_W-1:0] slot_d;
    always_comb begin
      slot_d = '0;
      if (route_q[ch] && slot_q != '1) begin
        slot_d = slot_q + CNT_W'(1);
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        slot_q <= '0;
      end else begin
        slot_q <= slot_d;
      end
    end
    // the first slot after entry is one cycle longer, as the gate follows the mode in one stage but a primary pulse in two
    a_slot_bounded: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE3
      slot_q <= CNT_W'(CHOP_PERIOD + 1)) else $error("channel slot too long");
  end

  assign ch_enable_o = route_q;
  assign first_pair_sel_o = first_q;
  assign second_pair_sel_o = second_q;
  assign pair_sel_o = pair_q;
  assign blank_n_o = blank_n_q;

  // checks
  a_pairs_locked: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE6
    first_q == second_q) else $error("pair select ffs not locked");
  a_first_toggles: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE2
    (mode_s2_q && primary_pulse) |=> (first_q != $past(first_q)))
    else $error("first pair ff did not toggle");
  a_first_steady: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE2
    (mode_s2_q && !primary_pulse) |=> $stable(first_q)) else $error("first pair ff moved without a pulse");
  a_second_toggles: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE4
    (mode_s2_q && primary_pulse) |=> (second_q != $past(second_q)))
    else $error("second pair ff did not toggle");
  a_primary_free: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE1
    $rose(primary_pulse) && mode_s2_q |=> !primary_pulse [*3])
    else $error("primary pulse too wide");
  a_mode_off_clear: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE1
    !mode_s2_q |=> (route_q == '0 && !first_q && !pair_q)) else $error("selects not cleared out of chop");
  a_secondary_synced: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE4
    (mode_s2_q && primary_pulse) |=> secondary_pulse) else $error("secondary not synced");
  a_secondary_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE4
    !mode_s2_q |=> !secondary_pulse) else $error("secondary ran out of chop");
  a_secondary_slaved: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE5
    secondary_pulse |-> $past(primary_pulse)) else $error("secondary ran free");
  a_trigger_source: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE7
    pair_trigger |-> ($past(first_q) && !first_q)) else $error("pair trigger without a falling lock");
  a_pair_trigger: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE8
    pair_pulse_q |-> $past(pair_trigger)) else $error("pair pulser untriggered");
  a_pulser_gap: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE9
    pair_pulse_q |=> !pair_pulse_q [*8]) else $error("pair pulses too close");
  a_pair_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE9
    (mode_s2_q && pair_pulse_q) |=> pair_q != $past(pair_q))
    else $error("pair ff did not toggle");
  a_pair_steady: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE9
    (mode_s2_q && !pair_pulse_q) |=> $stable(pair_q)) else $error("pair ff moved without a pulse");
  a_count_four: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE7
    (mode_s2_q && $fell(first_q)) ##1 mode_s2_q |-> ##1 $changed(pair_q))
    else $error("count of four broken");
  a_onehot_out: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE14
    $onehot0(route_q)) else $error("two channels routed");
  a_route_first: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE10
    (mode_s2_q && !pair_q) |=> (route_q[3:2] == 2'h0)) else $error("second pair not blocked");
  a_pair_route: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE11
    (mode_s2_q && pair_q) |=> (route_q[1:0] == 2'h0)) else $error("first pair not stopped");
  a_blank_inverts: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE13
    (primary_pulse || pair_pulse_q || secondary_pulse) |=> !blank_n_q) else $error("pulse not blanked");
  // entering chop mode is not a switch between channels, so it needs no blanking
  a_blank_covers: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE15
    $changed(route_q) && route_q != '0 && $past(route_q) != '0 |-> !blank_n_q)
    else $error("change not blanked");
  a_blank_bounded: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE15
    low_run_q <= CNT_W'(BLANK_LEN + 2)) else $error("blanking pulse too long");

  // covers for the main scenarios
  c_full_cycle: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    route_q == chop_seq_pkg::CH4_ONEHOT);
  c_third_channel: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    route_q == chop_seq_pkg::CH3_ONEHOT);
  c_pair_switch: cover property (@(posedge clk_i) disable iff (!rst_n_q) pair_pulse_q);
  c_blank: cover property (@(posedge clk_i) disable iff (!rst_n_q) $fell(blank_n_q));
  c_mode_exit: cover property (@(posedge clk_i) disable iff (!rst_n_q) $fell(mode_s2_q));
endmodule : four_channel_chop_sequencer
`default_nettype wire

// file: verification/beam_display_model.sv
// model of the output amplifier and beam: what the screen shows
`timescale 1ns/100ps
`default_nettype none
module beam_display_model (
  input wire logic clk_i, // clock
  input wire logic [3:0] ch_enable_i, // channel gates
  input wire logic blank_n_i, // beam blanking, active low
  output logic [3:0] shown_o = 4'h0, // last channel seen unblanked
  output logic [15:0] glitch_o = 16'h0, // switches with the beam on
  output logic [15:0] blanks_o = 16'h0 // blanking pulses seen
);
  logic [3:0] prev_q = 4'h0;
  logic blank_q = 1'b1;
  always @(posedge clk_i) begin
    prev_q <= ch_enable_i;
    blank_q <= blank_n_i;
    // the screen only shows a channel while the beam is on
    if (blank_n_i && ch_enable_i != 4'h0) shown_o <= ch_enable_i;
    // entering or leaving chop mode is not a switch between channels
    if (blank_n_i && prev_q != 4'h0 && ch_enable_i != 4'h0 && ch_enable_i != prev_q) begin
      glitch_o <= glitch_o + 16'h0001;
    end
    if (!blank_n_i && blank_q) blanks_o <= blanks_o + 16'h0001;
  end
endmodule : beam_display_model
`default_nettype wire

// file: verification/four_channel_chop_sequencer_bench.sv
// testbench for the four-channel chop sequencer
`timescale 1ns/100ps
`default_nettype none
module four_channel_chop_sequencer_bench;
  localparam int CP = 16;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic chop_mode_i = 1'b0;
  logic [3:0] ch_enable_o;
  logic first_pair_sel_o;
  logic second_pair_sel_o;
  logic pair_sel_o;
  logic blank_n_o;
  logic [3:0] shown;
  logic [15:0] glitches;
  logic [15:0] blanks;
  int err_total = 0;
  int num_checks = 0;
  always #2 clk_i = ~clk_i;
  four_channel_chop_sequencer #(.CHOP_PERIOD(CP), .BLANK_LEN(3)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .chop_mode_i(chop_mode_i), .ch_enable_o(ch_enable_o), .first_pair_sel_o(first_pair_sel_o),
    .second_pair_sel_o(second_pair_sel_o), .pair_sel_o(pair_sel_o), .blank_n_o(blank_n_o));
  beam_display_model u_beam (.clk_i(clk_i), .ch_enable_i(ch_enable_o), .blank_n_i(blank_n_o),
    .shown_o(shown), .glitch_o(glitches), .blanks_o(blanks));
  task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task wait_step(output int n);
    logic [3:0] old;
    old = shown;
    n = 0;
    while (shown === old && n < 60) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_step
  // chop must always restart on channel 1
  task first_gate;
    int n;
    n = 0;
    while (ch_enable_o === 4'h0 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check("restart channel", ch_enable_o, 4'h1);
  endtask : first_gate
  task run_sequence;
    logic [3:0] exp [4];
    int n;
    logic [15:0] b;
    exp = '{4'h1, 4'h2, 4'h4, 4'h8};
    chop_mode_i = 1'b1;
    wait_step(n);
    check("first channel", shown, 4'h1);
    for (int i = 1; i <= 8; i++) begin
      b = blanks;
      wait_step(n);
      check("order", shown, exp[i % 4]);
      check("pair lock", {3'h0, second_pair_sel_o}, {3'h0, i[0]});
      check("pair route", {3'h0, pair_sel_o}, {3'h0, (i % 4) > 1});
      check("first select", {3'h0, first_pair_sel_o}, {3'h0, i[0]});
      check("blank pulse", {3'h0, blanks > b}, 4'h1);
      check("step length", {3'h0, n >= CP - 2 && n <= CP + 6}, 4'h1);
    end
    check("unblanked switch", {3'h0, glitches == 16'h0}, 4'h1);
  endtask : run_sequence
  task mode_off;
    chop_mode_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("gates off", ch_enable_o, 4'h0);
    chop_mode_i = 1'b1;
    first_gate();
  endtask : mode_off
  task mid_reset;
    arst_n_i = 1'b0;
    @(negedge clk_i);
    check("reset gates", ch_enable_o, 4'h0);
    check("reset blank", {3'h0, blank_n_o}, 4'h1);
    arst_n_i = 1'b1;
    first_gate();
  endtask : mid_reset
  initial begin
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("idle gates", ch_enable_o, 4'h0);
    run_sequence();
    mode_off();
    repeat (30) @(negedge clk_i);
    mid_reset();
    complete_run();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
endmodule : four_channel_chop_sequencer_bench
`default_nettype wire
